/* File: rtl/interval_timer.sv */
// 8-bit reloadable interval timer with Wishbone register access
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module interval_timer (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [3:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// Interrupt
	output logic             o_irq
);
	tick_if tk ();

	logic        mode_reg;
	logic        rsv6_reg;
	logic [2:0]  clk_sel_reg;
	logic [7:0]  count_reg;
	logic [7:0]  count_next;
	logic [7:0]  reload_reg;
	logic        ovf_flag_reg;
	logic        ovf_en_reg;
	logic        ack_reg;
	logic [31:0] rdat_reg;
	logic        irq_reg;
	logic        req;
	logic        wr;
	logic        rd;
	logic        wr_mode;
	logic        wr_reload;
	logic        wr_mask;
	logic        rd_stat;
	logic        overflow;
	logic [7:0]  mode_view;

	prescaler u_pre (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.tk       (tk.pre)
	);

	assign tk.sel    = clk_sel_reg;
	assign req       = i_wb_cyc && i_wb_stb && !ack_reg;
	assign wr        = req && i_wb_we && i_wb_sel[0];
	assign rd        = req && !i_wb_we;
	assign wr_mode   = wr && (i_wb_adr == interval_timer_pkg::OFS_MODE);
	assign wr_reload = wr && (i_wb_adr == interval_timer_pkg::OFS_COUNT);
	assign wr_mask   = wr && (i_wb_adr == interval_timer_pkg::OFS_IRQ_MASK);
	assign rd_stat   = rd && (i_wb_adr == interval_timer_pkg::OFS_IRQ_STAT);
	assign overflow  = tk.tick &&
	                   (count_reg == interval_timer_pkg::COUNT_MAX);
	assign mode_view = {mode_reg, rsv6_reg,
	                    interval_timer_pkg::ONES_FIELD, clk_sel_reg};

	// Mode and clock select register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_reg    <= 1'b0;
			rsv6_reg    <= 1'b1;
			clk_sel_reg <= 3'h0;
		end else if (wr_mode) begin
			mode_reg    <= i_wb_dat[interval_timer_pkg::MODE_BIT];
			rsv6_reg    <= i_wb_dat[interval_timer_pkg::RSV6_BIT];
			clk_sel_reg <= i_wb_dat[2:0];
		end
	end

	// Reload register, written through the shared counter address
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			reload_reg <= interval_timer_pkg::RELOAD_RESET;
		end else if (wr_reload) begin
			reload_reg <= i_wb_dat[7:0];
		end
	end

	// Counter next value: software load first, then overflow, then tick
	always_comb begin
		count_next = count_reg;
		if (wr_reload) begin
			count_next = i_wb_dat[7:0];
		end else if (overflow) begin
			if (mode_reg) begin
				count_next = reload_reg;
			end else begin
				count_next = interval_timer_pkg::COUNT_RESET;
			end
		end else if (tk.tick) begin
			count_next = count_reg + 8'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_reg <= interval_timer_pkg::COUNT_RESET;
		end else begin
			count_reg <= count_next;
		end
	end

	// Overflow flag: set wins over clear-on-read
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ovf_flag_reg <= 1'b0;
		end else if (overflow) begin
			ovf_flag_reg <= 1'b1;
		end else if (rd_stat) begin
			ovf_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ovf_en_reg <= 1'b0;
		end else if (wr_mask) begin
			ovf_en_reg <= i_wb_dat[0];
		end
	end

	// Interrupt level, masked by the enable
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (ovf_flag_reg || overflow) && ovf_en_reg &&
			           !(wr_mask && !i_wb_dat[0]) &&
			           !(rd_stat && !overflow);
		end
	end

	// Bus answer: one cycle after the request, unmapped reads give zero
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg  <= req;
			rdat_reg <= 32'h0000_0000;
			if (rd) begin
				case (i_wb_adr)
					interval_timer_pkg::OFS_MODE:
						rdat_reg <= {24'h00_0000, mode_view};
					interval_timer_pkg::OFS_COUNT:
						rdat_reg <= {24'h00_0000, count_reg};
					interval_timer_pkg::OFS_IRQ_STAT:
						rdat_reg <= {31'h0000_0000, ovf_flag_reg};
					interval_timer_pkg::OFS_IRQ_MASK:
						rdat_reg <= {31'h0000_0000, ovf_en_reg};
					default:
						rdat_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;
	assign o_irq    = irq_reg;

	wrap_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(overflow && !mode_reg && !wr_reload) |=> count_reg == 8'h00)
		else $error("interval overflow did not wrap");
	auto_reload_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(overflow && mode_reg && !wr_reload) |=>
		count_reg == $past(reload_reg))
		else $error("auto reload value not loaded");
	sw_load_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_reload |=> count_reg == $past(i_wb_dat[7:0]) &&
		reload_reg == count_reg)
		else $error("reload write did not load counter");
	sw_priority_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_reload && tk.tick) |=> count_reg == $past(i_wb_dat[7:0]))
		else $error("tick overrode software load");
	count_step_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(tk.tick && !overflow && !wr_reload) |=>
		count_reg == $past(count_reg) + 8'h01)
		else $error("counter did not step");
	count_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(!tk.tick && !wr_reload) |=> $stable(count_reg))
		else $error("counter moved without tick");
	flag_set_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		overflow |=> ovf_flag_reg)
		else $error("overflow flag not set");
	irq_gate_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!ovf_en_reg |=> !o_irq)
		else $error("interrupt raised while disabled");
	ones_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd && i_wb_adr == interval_timer_pkg::OFS_MODE) |=>
		o_wb_dat[5:3] == 3'h7)
		else $error("mode bits 5..3 not read as one");
	no_tick_rsv_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(clk_sel_reg == interval_timer_pkg::SEL_RESERVED) |-> !tk.tick)
		else $error("tick on reserved select");
	mode_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_mode |=> mode_reg == $past(i_wb_dat[interval_timer_pkg::MODE_BIT]))
		else $error("mode bit not written");

	// Bus handshake
	ack_pulse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");

	ack_answer_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("request not acknowledged");

	ack_cause_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
		else $error("ack without request");

	dat_idle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("read data not zero outside ack");

	write_dat_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(req && i_wb_we) |=> o_wb_dat == 32'h0000_0000)
		else $error("write answered with data");

	// Register read-back
	upper_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_wb_dat[31:8] == 24'h00_0000)
		else $error("upper read data bits not zero");

	count_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd && i_wb_adr == interval_timer_pkg::OFS_COUNT) |=>
		o_wb_dat[7:0] == $past(count_reg))
		else $error("counter read wrong");

	mode_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd && i_wb_adr == interval_timer_pkg::OFS_MODE) |=>
		o_wb_dat[7:0] == $past(mode_view))
		else $error("mode read wrong");

	stat_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rd_stat |=> o_wb_dat[0] == $past(ovf_flag_reg))
		else $error("status read wrong");

	mask_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd && i_wb_adr == interval_timer_pkg::OFS_IRQ_MASK) |=>
		o_wb_dat[0] == $past(ovf_en_reg))
		else $error("mask read wrong");

	unmapped_read_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd && i_wb_adr != interval_timer_pkg::OFS_MODE &&
		i_wb_adr != interval_timer_pkg::OFS_COUNT &&
		i_wb_adr != interval_timer_pkg::OFS_IRQ_STAT &&
		i_wb_adr != interval_timer_pkg::OFS_IRQ_MASK) |=>
		o_wb_dat == 32'h0000_0000)
		else $error("unmapped read not zero");

	// Flag and interrupt
	flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(rd_stat && !overflow) |=> !ovf_flag_reg)
		else $error("status read did not clear flag");

	flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(!overflow && !rd_stat) |=> $stable(ovf_flag_reg))
		else $error("flag moved without cause");

	flag_cause_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$rose(ovf_flag_reg) |-> $past(overflow))
		else $error("flag set without overflow");

	irq_follow_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(ovf_flag_reg && ovf_en_reg && !rd_stat && !wr_mask) |=>
		o_irq)
		else $error("enabled flag gave no interrupt");

	ovf_irq_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(overflow && ovf_en_reg && !wr_mask) |=> o_irq)
		else $error("overflow gave no interrupt");

	irq_cause_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_irq |-> $past(ovf_flag_reg || overflow))
		else $error("interrupt without flag");

	irq_drop_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_mask && !i_wb_dat[0]) |=> !o_irq)
		else $error("interrupt kept after disable");

	// Register writes and tick spacing
	mask_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_mask |=> ovf_en_reg == $past(i_wb_dat[0]))
		else $error("enable not written");

	enable_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!wr_mask |=> $stable(ovf_en_reg))
		else $error("enable moved without write");

	reload_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_reload |=> reload_reg == $past(i_wb_dat[7:0]))
		else $error("reload not written");

	reload_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!wr_reload |=> $stable(reload_reg))
		else $error("reload moved without write");

	sel_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_mode |=> clk_sel_reg == $past(i_wb_dat[2:0]))
		else $error("clock select not written");

	mode_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!wr_mode |=> $stable(mode_reg) && $stable(clk_sel_reg))
		else $error("mode moved without write");

	rsv_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		wr_mode |=>
		rsv6_reg == $past(i_wb_dat[interval_timer_pkg::RSV6_BIT]))
		else $error("reserved bit not stored");

	rsv_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!wr_mode |=> $stable(rsv6_reg))
		else $error("reserved bit moved without write");

	write_sel0_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(req && i_wb_we && !i_wb_sel[0]) |=>
		$stable(reload_reg) && $stable(mode_reg) && $stable(ovf_en_reg))
		else $error("write without byte select took effect");

	tick_gap_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		tk.tick |=> !tk.tick)
		else $error("ticks on consecutive cycles");
endmodule // interval_timer

/* File: rtl/interval_timer_pkg.sv */
// Package with register map, field layout and prescaler constants
package interval_timer_pkg;
	localparam logic [3:0] OFS_MODE      = 4'h0;
	localparam logic [3:0] OFS_COUNT     = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT  = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK  = 4'hc;
	localparam int         MODE_BIT      = 7;
	localparam int         RSV6_BIT      = 6;
	localparam logic [2:0] ONES_FIELD    = 3'h7;
	localparam logic [2:0] SEL_RESERVED  = 3'h7;
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] COUNT_MAX     = 8'hff;
	localparam logic [7:0] RELOAD_RESET  = 8'h00;
	localparam int         PRESCALE_W    = 13;
	localparam logic [3:0] TAP_8192      = 4'hc;
	localparam logic [3:0] TAP_2048      = 4'ha;
	localparam logic [3:0] TAP_512       = 4'h8;
	localparam logic [3:0] TAP_256       = 4'h7;
	localparam logic [3:0] TAP_64        = 4'h5;
	localparam logic [3:0] TAP_16        = 4'h3;
	localparam logic [3:0] TAP_4         = 4'h1;
endpackage

/* File: rtl/tick_if.sv */
// Interface carrying the count tick from prescaler to timer core
`timescale 1ns/1ps
interface tick_if;
	logic [2:0] sel;
	logic       tick;
	modport ctrl (output sel, input tick);
	modport pre  (input sel, output tick);
endinterface

/* File: rtl/prescaler.sv */
// Free-running prescaler producing one tick per selected divide period
`timescale 1ns/1ps
module prescaler (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// Tick port
	tick_if.pre       tk
);
	logic [interval_timer_pkg::PRESCALE_W-1:0] div_reg;
	logic [interval_timer_pkg::PRESCALE_W-1:0] div_next;
	logic [3:0]                                tap;

	function automatic logic [3:0] tap_of(input logic [2:0] s);
		case (s)
			3'h0:    tap_of = interval_timer_pkg::TAP_8192;
			3'h1:    tap_of = interval_timer_pkg::TAP_2048;
			3'h2:    tap_of = interval_timer_pkg::TAP_512;
			3'h3:    tap_of = interval_timer_pkg::TAP_256;
			3'h4:    tap_of = interval_timer_pkg::TAP_64;
			3'h5:    tap_of = interval_timer_pkg::TAP_16;
			default: tap_of = interval_timer_pkg::TAP_4;
		endcase
	endfunction

	assign tap      = tap_of(tk.sel);
	assign div_next = div_reg + 1'b1;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	// Tick when all bits up to the tap are ones; reserved code gives none
	always_comb begin
		logic [interval_timer_pkg::PRESCALE_W-1:0] m;
		m = '0;
		for (int i = 0; i < interval_timer_pkg::PRESCALE_W; i++) begin
			if (i <= int'(tap)) begin
				m[i] = 1'b1;
			end
		end
		tk.tick = ((div_reg & m) == m) &&
		          (tk.sel != interval_timer_pkg::SEL_RESERVED);
	end
endmodule // prescaler

/* File: verification/tb_interval_timer.sv */
// Self-checking bench for the reloadable interval timer
`timescale 1ns/1ps
module tb_interval_timer;
	logic        i_clk    = 1'b0;
	logic        i_arst_n = 1'b0;
	logic        wb_cyc   = 1'b0;
	logic        wb_stb   = 1'b0;
	logic        wb_we    = 1'b0;
	logic [3:0]  wb_adr   = 4'h0;
	logic [3:0]  wb_sel   = 4'h0;
	logic [31:0] wb_dat   = 32'h0;
	logic [31:0] o_wb_dat;
	logic        o_wb_ack;
	logic        o_irq;
	logic [32:0] notes[$];
	logic [32:0] nt;
	logic [31:0] rd;
	logic [7:0]  r;
	int          errors   = 0;
	int          n_checks = 0;
	int          cycles   = 0;
	int          t0;
	int          dv[7]    = '{8192, 2048, 512, 256, 64, 16, 4};

	interval_timer interval_timer_inst (
		.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
		.i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq)
	);

	initial begin
		forever #2.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One classic cycle; a read may note its expected data for the monitor
	task bus(input logic [3:0] a, input logic w, input logic [7:0] d,
		input logic cmp, input logic [7:0] e);
		int k;
		notes.push_back({cmp, 24'h0, e});
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat <= {24'h0, d};
		k = 0;
		@(posedge i_clk);
		while (o_wb_ack !== 1'b1 && k < 20) begin
			@(posedge i_clk);
			k++;
		end
		if (k == 20)
			errors++;
		rd = o_wb_dat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge i_clk);
	endtask

	task wait_rise;
		int k;
		k = 0;
		while (o_irq !== 1'b1 && k < 3000) begin
			@(posedge i_clk);
			k++;
		end
		if (k == 3000)
			errors++;
	endtask

	// Monitor: each ack retires the oldest note
	always @(posedge i_clk) begin
		if (o_wb_ack === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			if (nt[32])
				check(o_wb_dat, nt[31:0]);
		end
	end

	initial begin
		#400000;
		errors++;
		conclude;
	end

	initial begin
		void'($urandom(2416));
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		bus(4'h0, 1'b0, 8'h00, 1'b1, 8'h78);
		bus(4'h4, 1'b0, 8'h00, 1'b1, 8'h00);
		bus(4'h2, 1'b0, 8'h00, 1'b1, 8'h00);
		r = 8'($urandom);
		// Selector code 7 freezes the count so reads are exact
		bus(4'h0, 1'b1, {2'b01, r[2:0], 3'h7}, 1'b0, 8'h00);
		bus(4'h0, 1'b0, 8'h00, 1'b1, 8'h7f);
		bus(4'h4, 1'b1, r, 1'b0, 8'h00);
		bus(4'h4, 1'b0, 8'h00, 1'b1, r);
		bus(4'h6, 1'b1, 8'h55, 1'b0, 8'h00);
		bus(4'h4, 1'b0, 8'h00, 1'b1, r);
		for (int i = 0; i < 7; i++) begin
			bus(4'h4, 1'b1, 8'h00, 1'b0, 8'h00);
			bus(4'h0, 1'b1, 8'h78 | 8'(i), 1'b0, 8'h00);
			repeat (dv[i] * 4) @(posedge i_clk);
			bus(4'h0, 1'b1, 8'h7f, 1'b0, 8'h00);
			bus(4'h4, 1'b0, 8'h00, 1'b0, 8'h00);
			check(rd >= 3 && rd <= 5, 32'h1);
		end
		for (int m = 0; m < 2; m++) begin
			r = 8'hc0 + 8'($urandom % 63);
			bus(4'h0, 1'b1, 8'h7f, 1'b0, 8'h00);
			bus(4'h4, 1'b1, r, 1'b0, 8'h00);
			bus(4'h8, 1'b0, 8'h00, 1'b0, 8'h00);
			bus(4'hc, 1'b1, 8'h01, 1'b0, 8'h00);
			bus(4'h0, 1'b1, {m[0], 7'h7e}, 1'b0, 8'h00);
			wait_rise;
			t0 = cycles;
			bus(4'h8, 1'b0, 8'h00, 1'b1, 8'h01);
			wait_rise;
			check(cycles - t0, m ? 4 * (256 - r) : 1024);
		end
		bus(4'hc, 1'b1, 8'h00, 1'b0, 8'h00);
		bus(4'h8, 1'b0, 8'h00, 1'b0, 8'h00);
		repeat (1100) @(posedge i_clk);
		check(o_irq, 32'h0);
		// Freeze the count so no overflow lands between the two reads
		bus(4'h0, 1'b1, 8'h7f, 1'b0, 8'h00);
		bus(4'h8, 1'b0, 8'h00, 1'b1, 8'h01);
		bus(4'h8, 1'b0, 8'h00, 1'b1, 8'h00);
		i_arst_n <= 1'b0;
		@(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		check(o_irq, 32'h0);
		bus(4'h0, 1'b0, 8'h00, 1'b1, 8'h78);
		bus(4'h4, 1'b0, 8'h00, 1'b1, 8'h00);
		conclude;
	end
endmodule // tb_interval_timer
